// ===== hdl/afr_host.sv
// Host controller that watches and decodes the amplifier fault report lines.
`timescale 1ns/100ps
`default_nettype none
`include "afr_defines.svh"

module afr_host #(
  parameter int unsigned WINDOW_CYCLES = `AFR_FAULT_WINDOW_CYC,
  parameter int unsigned REDUCE_LIMIT  = `AFR_REDUCE_LIMIT,
  parameter int unsigned OFF_LIMIT     = `AFR_OFF_LIMIT
) (
  // Clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    arst_n_i,
  // Fault lines from the power stages, asynchronous, active low
  input  wire logic                    temp_warning_n_i,
  input  wire logic                    primary_shutdown_n_i,
  input  wire logic                    secondary_shutdown_n_i,
  // Host side control
  input  wire logic                    policy_clear_i,
  // Mode selects to the stages
  output logic                         mode_select_a_o,
  output logic                         mode_select_b_o,
  output logic                         mode_select_c_o,
  // Decoded conditions
  output afr_pkg::afr_cond_t           primary_cond_o,
  output afr_pkg::afr_cond_t           secondary_cond_o,
  output logic                         temp_warning_o,
  // Fault report events and counts
  output logic                         primary_fault_pulse_o,
  output logic                         secondary_fault_pulse_o,
  output logic [`AFR_COUNT_W-1:0]      primary_fault_count_o,
  output logic [`AFR_COUNT_W-1:0]      secondary_fault_count_o,
  // Secondary channel policy
  output logic                         secondary_reduce_o,
  output logic                         secondary_off_o
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  localparam int unsigned COUNT_MAX = (1 << `AFR_COUNT_W) - 1;

  if (WINDOW_CYCLES < 1) begin : g_bad_window
    $error("WINDOW_CYCLES must be at least one");
  end
  if (REDUCE_LIMIT < 1 || OFF_LIMIT <= REDUCE_LIMIT || OFF_LIMIT > COUNT_MAX) begin : g_bad_lim
    $error("Need 1 <= REDUCE_LIMIT < OFF_LIMIT <= counter maximum");
  end

  localparam logic [`AFR_TIMER_W-1:0] WIN_LOAD   = `AFR_TIMER_W'(WINDOW_CYCLES - 1);
  localparam logic [`AFR_COUNT_W-1:0] REDUCE_CNT = `AFR_COUNT_W'(REDUCE_LIMIT);
  localparam logic [`AFR_COUNT_W-1:0] OFF_CNT    = `AFR_COUNT_W'(OFF_LIMIT);
  localparam logic [`AFR_COUNT_W-1:0] CNT_ONE    = `AFR_COUNT_W'(1);
  localparam logic [`AFR_COUNT_W-1:0] CNT_FULL   = `AFR_COUNT_W'(COUNT_MAX);

  // --------------------------------------------------------------------------
  // Decode of the warning and group shutdown pair
  // --------------------------------------------------------------------------
  function automatic afr_pkg::afr_cond_t decode_cond(input logic warn_n,
                                                     input logic group_shutdown_n);
    afr_pkg::afr_cond_t cond;
    case ({warn_n, group_shutdown_n})
      2'h0:    cond = afr_pkg::COND_TEMP_CUR_ERR;
      2'h1:    cond = afr_pkg::COND_TEMP_WARN;
      2'h2:    cond = afr_pkg::COND_UVLO_CUR_ERR;
      default: cond = afr_pkg::COND_NORMAL;
    endcase
    return cond;
  endfunction : decode_cond

  // Saturating so a long fault storm cannot wrap back to a small count
  function automatic logic [`AFR_COUNT_W-1:0] count_up(input logic [`AFR_COUNT_W-1:0] cnt);
    return (cnt == CNT_FULL) ? cnt : cnt + CNT_ONE;
  endfunction : count_up

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  afr_pkg::afr_state_t state;
  afr_pkg::afr_state_t next_state;
  afr_pkg::afr_lines_t pins;

  // Sync stages reset to the idle high level, so that a release alone
  // never looks like a falling line and counts a false report
  localparam afr_pkg::afr_state_t STATE_RESET = '{
    sync1:       `AFR_LINES_IDLE,
    sync2:       `AFR_LINES_IDLE,
    prev:        `AFR_LINES_IDLE,
    pri_cond:    afr_pkg::COND_NORMAL,
    sec_cond:    afr_pkg::COND_NORMAL,
    warn_active: 1'h0,
    pri_event:   1'h0,
    sec_event:   1'h0,
    pri_count:   `AFR_COUNT_W'h0,
    sec_count:   `AFR_COUNT_W'h0,
    win_faults:  `AFR_COUNT_W'h0,
    win_timer:   `AFR_TIMER_W'h0,
    sec_state:   afr_pkg::SEC_RUN,
    sec_reduce:  1'h0,
    sec_off:     1'h0,
    mode_select: `AFR_MODE_AUTO
  };

  // Lines are wired-OR open-drain; the host only listens, never drives them
  assign pins.warn_n = temp_warning_n_i;
  assign pins.pri_n  = primary_shutdown_n_i;
  assign pins.sec_n  = secondary_shutdown_n_i;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic                    pri_fall;
    logic                    sec_fall;
    logic                    win_end;
    logic [`AFR_COUNT_W-1:0] win_next;
    pri_fall = 1'h0;
    sec_fall = 1'h0;
    win_end  = 1'h0;
    win_next = `AFR_COUNT_W'h0;
    next_state = state;

    next_state.sync1 = pins;
    next_state.sync2 = state.sync1;
    next_state.prev  = state.sync2;
    // All selects low: stages restart on their own after a fault
    next_state.mode_select = `AFR_MODE_AUTO;

    next_state.pri_cond    = decode_cond(state.sync2.warn_n, state.sync2.pri_n);
    next_state.sec_cond    = decode_cond(state.sync2.warn_n, state.sync2.sec_n);
    next_state.warn_active = ~state.sync2.warn_n;

    // A stage in auto recovery reports with a short low pulse; count its start
    pri_fall = state.prev.pri_n & ~state.sync2.pri_n;
    sec_fall = state.prev.sec_n & ~state.sync2.sec_n;
    next_state.pri_event = pri_fall;
    next_state.sec_event = sec_fall;

    // New report wins over a clear in the same cycle,
    // so that a fault is never lost to a clear
    if (pri_fall) begin
      next_state.pri_count = policy_clear_i ? CNT_ONE : count_up(state.pri_count);
    end else if (policy_clear_i) begin
      next_state.pri_count = `AFR_COUNT_W'h0;
    end
    if (sec_fall) begin
      next_state.sec_count = policy_clear_i ? CNT_ONE : count_up(state.sec_count);
    end else if (policy_clear_i) begin
      next_state.sec_count = `AFR_COUNT_W'h0;
    end

    // Repeat window: reports are only "repeated" if they fall in one window
    // Free-running window is cheap, but a burst that straddles its end is
    // split in two and must run longer before the policy reacts
    win_end = (state.win_timer == `AFR_TIMER_W'h0);
    next_state.win_timer = win_end ? WIN_LOAD : state.win_timer - `AFR_TIMER_W'h1;
    if (win_end || policy_clear_i) begin
      win_next = sec_fall ? CNT_ONE : `AFR_COUNT_W'h0;
    end else begin
      win_next = sec_fall ? count_up(state.win_faults) : state.win_faults;
    end
    next_state.win_faults = win_next;

    // Primary channels are never touched by this policy
    case (state.sec_state)
      afr_pkg::SEC_RUN: begin
        if (win_next >= OFF_CNT) begin
          next_state.sec_state = afr_pkg::SEC_OFF;
        end else if (win_next >= REDUCE_CNT) begin
          next_state.sec_state = afr_pkg::SEC_REDUCED;
        end
      end
      afr_pkg::SEC_REDUCED: begin
        if (win_next >= OFF_CNT) begin
          next_state.sec_state = afr_pkg::SEC_OFF;
        end else if (policy_clear_i) begin
          next_state.sec_state = afr_pkg::SEC_RUN;
        end
      end
      afr_pkg::SEC_OFF: begin
        if (policy_clear_i) begin
          next_state.sec_state = afr_pkg::SEC_RUN;
        end
      end
      default: begin
        next_state.sec_state = afr_pkg::SEC_RUN;
      end
    endcase
    next_state.sec_reduce = (next_state.sec_state == afr_pkg::SEC_REDUCED);
    next_state.sec_off    = (next_state.sec_state == afr_pkg::SEC_OFF);
  end

  // --------------------------------------------------------------------------
  // Register
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all straight from the state register
  // --------------------------------------------------------------------------
  assign mode_select_a_o         = state.mode_select[2];
  assign mode_select_b_o         = state.mode_select[1];
  assign mode_select_c_o         = state.mode_select[0];
  assign primary_cond_o          = state.pri_cond;
  assign secondary_cond_o        = state.sec_cond;
  assign temp_warning_o          = state.warn_active;
  assign primary_fault_pulse_o   = state.pri_event;
  assign secondary_fault_pulse_o = state.sec_event;
  assign primary_fault_count_o   = state.pri_count;
  assign secondary_fault_count_o = state.sec_count;
  assign secondary_reduce_o      = state.sec_reduce;
  assign secondary_off_o         = state.sec_off;

endmodule : afr_host

`default_nettype wire

// ===== hdl/afr_defines.svh
// Constants for the amplifier fault report aggregator host controller.
//
// Behaviour
// - Warning low: shutdown low is temperature/current error, high is warning only.
// - Warning high with shutdown low decodes as undervoltage lockout or current error.
// - Warning high with shutdown high decodes as normal operation.
// - Host may attenuate or stop secondary channels on repeated secondary faults.
`ifndef AFR_DEFINES_SVH
`define AFR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define AFR_REF_CLK_KHZ      200000
`define AFR_FAULT_WINDOW_MS  100
`define AFR_FAULT_WINDOW_CYC (`AFR_FAULT_WINDOW_MS * `AFR_REF_CLK_KHZ)

// ----------------------------------------------------------------------------
// Counts and field positions
// ----------------------------------------------------------------------------
`define AFR_COUNT_W          8
`define AFR_TIMER_W          32
`define AFR_REDUCE_LIMIT     3
`define AFR_OFF_LIMIT        6
`define AFR_LINE_WARN        2
`define AFR_LINE_PRI         1
`define AFR_LINE_SEC         0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define AFR_LINES_IDLE       3'h7
`define AFR_MODE_AUTO        3'h0

`endif

// ===== hdl/afr_pkg.sv
// Types for the amplifier fault report aggregator host controller.
`default_nettype none
`include "afr_defines.svh"

package afr_pkg;

  // --------------------------------------------------------------------------
  // Decoded device condition, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    COND_NORMAL       = 4'h1,
    COND_TEMP_WARN    = 4'h2,
    COND_TEMP_CUR_ERR = 4'h4,
    COND_UVLO_CUR_ERR = 4'h8
  } afr_cond_t;

  // --------------------------------------------------------------------------
  // Secondary channel policy
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SEC_RUN     = 3'h1,
    SEC_REDUCED = 3'h2,
    SEC_OFF     = 3'h4
  } afr_sec_state_t;

  // Fault lines, all active low: warn, primary, secondary
  typedef struct packed {
    logic warn_n;
    logic pri_n;
    logic sec_n;
  } afr_lines_t;

  typedef struct packed {
    afr_lines_t                 sync1;
    afr_lines_t                 sync2;
    afr_lines_t                 prev;
    afr_cond_t                  pri_cond;
    afr_cond_t                  sec_cond;
    logic                       warn_active;
    logic                       pri_event;
    logic                       sec_event;
    logic [`AFR_COUNT_W-1:0]    pri_count;
    logic [`AFR_COUNT_W-1:0]    sec_count;
    logic [`AFR_COUNT_W-1:0]    win_faults;
    logic [`AFR_TIMER_W-1:0]    win_timer;
    afr_sec_state_t             sec_state;
    logic                       sec_reduce;
    logic                       sec_off;
    logic [2:0]                 mode_select;
  } afr_state_t;

endpackage : afr_pkg

`default_nettype wire

// ===== bench/afr_stage_model.sv
// Model of the eight power stages and their open-drain report lines.
`timescale 1ns/100ps
`default_nettype none
module afr_stage_model (
  // From host and bench
  input  wire logic [2:0] mode_select_i,
  input  wire logic [7:0] warn_i,
  input  wire logic [7:0] fault_i,
  // Wired-OR lines, pulled up
  output tri1             warn_n_o,
  output tri1             pri_n_o,
  output tri1             sec_n_o
);
  // Stages 0, 1 and 6 are front left, front right and center
  localparam logic [7:0] PRI = 8'h43;
  // Without auto recovery every stage would sit in shutdown
  wire [7:0] down = fault_i | {8{|mode_select_i}};
  for (genvar i = 0; i < 8; i++) begin : g_stage
    assign warn_n_o = warn_i[i] ? 1'h0 : 1'hZ;
    assign pri_n_o  = down[i] & PRI[i] ? 1'h0 : 1'hZ;
    assign sec_n_o  = down[i] & !PRI[i] ? 1'h0 : 1'hZ;
  end
endmodule : afr_stage_model
`default_nettype wire

// ===== bench/afr_host_assertions.sv
// Port-level assertions for the fault report host controller.
`timescale 1ns/100ps
`default_nettype none
`include "afr_defines.svh"
module afr_host_assertions (
  // Clock, reset and lines
  input wire logic               ref_clk_i,
  input wire logic               arst_n_i,
  input wire logic               temp_warning_n_i,
  input wire logic               primary_shutdown_n_i,
  input wire logic               secondary_shutdown_n_i,
  input wire logic               policy_clear_i,
  // Design outputs
  input wire logic               mode_select_a_o,
  input wire logic               mode_select_b_o,
  input wire logic               mode_select_c_o,
  input wire afr_pkg::afr_cond_t primary_cond_o,
  input wire afr_pkg::afr_cond_t secondary_cond_o,
  input wire logic               primary_fault_pulse_o,
  input wire logic               secondary_fault_pulse_o,
  input wire logic [`AFR_COUNT_W-1:0] secondary_fault_count_o,
  input wire logic               secondary_reduce_o,
  input wire logic               secondary_off_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Old samples reach back into reset until this saturates
  logic [2:0] age;
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  function automatic afr_pkg::afr_cond_t dec(input logic w, input logic s);
    return w ? (s ? afr_pkg::COND_NORMAL : afr_pkg::COND_UVLO_CUR_ERR)
             : (s ? afr_pkg::COND_TEMP_WARN : afr_pkg::COND_TEMP_CUR_ERR);
  endfunction : dec
  property p_mode; {mode_select_a_o, mode_select_b_o, mode_select_c_o} == 3'h0; endproperty
  a_mode: assert property (p_mode) else $error("mode select not low");
  property p_pri_dec; age == 3'h7 |-> primary_cond_o ==
    dec($past(temp_warning_n_i, 3), $past(primary_shutdown_n_i, 3)); endproperty
  a_pri_dec: assert property (p_pri_dec) else $error("primary decode");
  property p_sec_dec; age == 3'h7 |-> secondary_cond_o ==
    dec($past(temp_warning_n_i, 3), $past(secondary_shutdown_n_i, 3)); endproperty
  a_sec_dec: assert property (p_sec_dec) else $error("secondary decode");
  property p_pulse; age == 3'h7 |-> primary_fault_pulse_o ==
    ($past(primary_shutdown_n_i, 4) && !$past(primary_shutdown_n_i, 3)); endproperty
  a_pulse: assert property (p_pulse) else $error("primary pulse");
  property p_sec_pulse; age == 3'h7 |-> secondary_fault_pulse_o ==
    ($past(secondary_shutdown_n_i, 4) && !$past(secondary_shutdown_n_i, 3)); endproperty
  a_sec_pulse: assert property (p_sec_pulse) else $error("secondary pulse");
  property p_count; secondary_fault_pulse_o && !$past(policy_clear_i) &&
    $past(secondary_fault_count_o) != 8'hFF |->
    secondary_fault_count_o == $past(secondary_fault_count_o) + 8'h01; endproperty
  a_count: assert property (p_count) else $error("secondary count");
  property p_clear; policy_clear_i ##1 !secondary_fault_pulse_o |->
    !secondary_reduce_o && !secondary_off_o && secondary_fault_count_o == 8'h00; endproperty
  a_clear: assert property (p_clear) else $error("policy clear");
endmodule : afr_host_assertions
bind afr_host afr_host_assertions i_chk (.ref_clk_i, .arst_n_i, .temp_warning_n_i,
  .primary_shutdown_n_i, .secondary_shutdown_n_i, .policy_clear_i, .mode_select_a_o,
  .mode_select_b_o, .mode_select_c_o, .primary_cond_o, .secondary_cond_o,
  .primary_fault_pulse_o, .secondary_fault_pulse_o, .secondary_fault_count_o,
  .secondary_reduce_o, .secondary_off_o);
`default_nettype wire

// ===== bench/tb_afr_host.sv
// Self-checking bench for the fault report host controller.
`timescale 1ns/100ps
`default_nettype none
module tb_afr_host;
  typedef struct packed {
    logic [7:0] w;
    logic [7:0] f;
    afr_pkg::afr_cond_t p;
    afr_pkg::afr_cond_t s;
  } afr_row_t;
  localparam afr_pkg::afr_cond_t N = afr_pkg::COND_NORMAL;
  localparam afr_pkg::afr_cond_t W = afr_pkg::COND_TEMP_WARN;
  localparam afr_pkg::afr_cond_t E = afr_pkg::COND_TEMP_CUR_ERR;
  localparam afr_pkg::afr_cond_t U = afr_pkg::COND_UVLO_CUR_ERR;
  localparam int WIN = 400;
  localparam afr_row_t ROWS [8] = '{'{8'h00, 8'h00, N, N}, '{8'h00, 8'h01, U, N},
    '{8'h00, 8'h42, U, N}, '{8'h00, 8'h84, N, U}, '{8'h80, 8'h00, W, W},
    '{8'h08, 8'h10, W, E}, '{8'h01, 8'h20, W, E}, '{8'hFF, 8'hFF, E, E}};
  logic       clk = 1'h0;
  logic       arst_n = 1'h0;
  logic       clr = 1'h0;
  logic [7:0] warn = 8'h00;
  logic [7:0] flt = 8'h00;
  logic [7:0] epc = 8'h00;
  logic [7:0] esc = 8'h00;
  tri1        warn_n, pri_n, sec_n;
  logic       ma, mb, mc, tw, pp, sp, red, off;
  logic [7:0] pcnt, scnt;
  afr_pkg::afr_cond_t pc, sc;
  int         cyc = 0;
  int         num_errors = 0;
  int         num_checks = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  afr_host #(.WINDOW_CYCLES(WIN)) i_dut (.ref_clk_i(clk), .arst_n_i(arst_n),
    .temp_warning_n_i(warn_n), .primary_shutdown_n_i(pri_n), .secondary_shutdown_n_i(sec_n),
    .policy_clear_i(clr), .mode_select_a_o(ma), .mode_select_b_o(mb), .mode_select_c_o(mc),
    .primary_cond_o(pc), .secondary_cond_o(sc), .temp_warning_o(tw),
    .primary_fault_pulse_o(pp), .secondary_fault_pulse_o(sp), .primary_fault_count_o(pcnt),
    .secondary_fault_count_o(scnt), .secondary_reduce_o(red), .secondary_off_o(off));
  afr_stage_model i_stages (.mode_select_i({ma, mb, mc}), .warn_i(warn), .fault_i(flt),
    .warn_n_o(warn_n), .pri_n_o(pri_n), .sec_n_o(sec_n));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Low and high for four cycles each, past the one-cycle re-arm
  task automatic hit(input logic [7:0] f);
    flt = f;
    repeat (4) @(negedge clk);
    flt = 8'h00;
    repeat (4) @(negedge clk);
  endtask : hit
  task automatic clear;
    clr = 1'h1;
    @(negedge clk);
    clr = 1'h0;
  endtask : clear
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (16) @(negedge clk);
    chk(pc, N);
    chk({ma, mb, mc}, 8'h00);
    arst_n = 1'h1;
    foreach (ROWS[i]) begin
      warn = ROWS[i].w;
      flt = ROWS[i].f;
      repeat (5) @(negedge clk);
      epc += |(ROWS[i].f & 8'h43);
      esc += |(ROWS[i].f & 8'hBC);
      chk(pc, ROWS[i].p);
      chk(sc, ROWS[i].s);
      chk(tw, |ROWS[i].w);
      chk(pcnt, epc);
      chk(scnt, esc);
      warn = 8'h00;
      flt = 8'h00;
      repeat (5) @(negedge clk);
    end
    $display("test rows done");
    clear();
    chk(scnt, 8'h00);
    repeat (6) hit(8'h43);
    chk(pcnt, 8'h06);
    chk({red, off}, 8'h00);
    // Two reports on each side of a window end must not add up
    while (cyc % WIN != 200) @(negedge clk);
    repeat (2) hit(8'h10);
    while (cyc % WIN != 200) @(negedge clk);
    repeat (2) hit(8'h10);
    chk({red, off}, 8'h00);
    hit(8'h10);
    chk({red, off}, 8'h02);
    repeat (3) hit(8'h10);
    chk({red, off}, 8'h01);
    chk(scnt, 8'h08);
    clear();
    chk({red, off}, 8'h00);
    $display("test policy done");
    // Report edge and clear sampled at the same edge: the report survives
    flt = 8'h10;
    repeat (2) @(negedge clk);
    clear();
    chk(scnt, 8'h01);
    hit(8'h01);
    chk(pcnt, 8'h01);
    $display("test clash done");
    arst_n = 1'h0;
    @(negedge clk);
    chk(pcnt, 8'h00);
    chk(scnt, 8'h00);
    arst_n = 1'h1;
    hit(8'h02);
    chk(pcnt, 8'h01);
    $display("test reset done");
    close_out();
  end
  initial begin
    #20000;
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out();
  end
endmodule : tb_afr_host
`default_nettype wire
